// ### rtl/pfs_map.svh
// register map, field positions, reset values and constants of the port 1 / port 2 function select block
// Notes on behaviour
// - expanded mode: port1 pin4 is wait input when wait select bit set, else ddr
// - expanded mode: port1 pin3 is bus request input when bus release enabled
// - expanded mode: port1 pin2 drives bus acknowledge when bus release enabled
// - port1 pin7 carries timer output when any output select bit nonzero
// - port1 pin6: interrupt 1 and/or conversion trigger inputs, else general io
// - port1 pin6 as general io takes direction from its own ddr bit
// - port1 pin5 is interrupt 0 input when its enable is set
// - port2 is general io only in single-chip mode, else bus control outputs
// - expanded: port2 pins 0..4 output address, rw, data, read, write strobes
// - single-chip: port2 pin is output when ddr bit 1, input when 0
// - port2 direction register is write-only and reads as all ones
// - port2 register bits 7..5 ignore writes and read as one
// - reset and hardware standby load port2 direction with e0
// - software standby keeps port2 direction and output drive
// - expanded mode holds all port2 direction bits at one
// - port2 data read returns latch for outputs, pin level for inputs
// - port1 pin1 outputs e clock, pin0 system clock when ddr set
// - single-chip: port1 pins 2 and 3 ignore bus release enable
// - port1 interrupt input pins stay readable through port1 data register
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH
`define PFS_ADDR_W        16
`define PFS_P1_DDR_ADDR   16'hfe80
`define PFS_P2_DDR_ADDR   16'hfe81
`define PFS_P1_DATA_ADDR  16'hfe82
`define PFS_P2_DATA_ADDR  16'hfe83
`define PFS_CTRL_ADDR     16'hfe88
`define PFS_P1_DDR_RST    8'h03
`define PFS_P1_HSB        8'h00
`define PFS_P1_DATA_RST   8'h00
`define PFS_P2_DDR_RST    8'he0
`define PFS_P2_DATA_RST   8'he0
`define PFS_P2_RSVD       8'he0
`define PFS_CTRL_RST      8'h00
`define PFS_UNMAPPED      8'h00
`define PFS_CTL_WAIT_SEL  0
`define PFS_CTL_BUS_REL   1
`define PFS_CTL_INT0E     2
`define PFS_CTL_INT1E     3
`define PFS_CTL_TRIG_EN   4
`endif

// ### rtl/pfs_pkg.sv
// types shared by the port function select block
package pfs_pkg;
    typedef enum logic [1:0] {
        PFS_IDLE,
        PFS_ACK
    } pfs_bus_state_t;
endpackage : pfs_pkg

// ### rtl/pfs_port2.sv
// port 2 registers and pin muxing
`timescale 1ns/10ps
`include "pfs_map.svh"
module pfs_port2 (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // mode
    input  wire logic       expanded,
    input  wire logic       hw_standby,
    // register writes
    input  wire logic       ddr_wr,
    input  wire logic       data_wr,
    input  wire logic [7:0] wdata,
    // bus strobes, address strobe in bit0 .. write strobe in bit4
    input  wire logic [4:0] bus_ctl,
    // pins
    input  wire logic [4:0] pin_in,
    output logic      [4:0] pin_out_nxt,
    output logic      [4:0] pin_oe_nxt,
    // read value of data register
    output logic      [7:0] data_rd
);
    logic [4:0] ddr_r;
    logic [4:0] data_r;
    wire  [4:0] ddr_eff = expanded ? 5'h1f : ddr_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ddr_r  <= 5'(`PFS_P2_DDR_RST);
            data_r <= 5'h00;
        end else begin
            if (hw_standby) begin
                ddr_r  <= 5'h00;
                data_r <= 5'h00;
            end else begin
                if (ddr_wr && !expanded)
                    ddr_r <= wdata[4:0];
                if (data_wr)
                    data_r <= wdata[4:0];
            end
        end
    end

    assign pin_oe_nxt  = ddr_eff;
    assign pin_out_nxt = expanded ? bus_ctl : data_r;
    assign data_rd = `PFS_P2_RSVD | {3'b000, (ddr_eff & data_r) | (~ddr_eff & pin_in)};
endmodule : pfs_port2

// ### rtl/pfs_top.sv
// port 1 / port 2 pin function select with avalon-mm register slave
`timescale 1ns/10ps
`include "pfs_map.svh"
module pfs_top
    import pfs_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // avalon-mm slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [7:0]  avs_writedata,
    output logic      [7:0]  avs_readdata,
    output logic             avs_waitrequest,
    // chip mode and standby
    input  wire logic        expanded,
    input  wire logic        hw_standby,
    // peripheral selects from other blocks
    input  wire logic [3:0]  timer_output_select,
    input  wire logic        timer_compare_out,
    input  wire logic        e_clock,
    input  wire logic        sys_clock,
    input  wire logic        bus_ack_out,
    input  wire logic [4:0]  bus_ctl,
    // port 1 pins
    input  wire logic [7:0]  p1_in,
    output logic      [7:0]  p1_out,
    output logic      [7:0]  p1_oe,
    // port 2 pins
    input  wire logic [4:0]  p2_in,
    output logic      [4:0]  p2_out,
    output logic      [4:0]  p2_oe,
    // peripheral inputs taken from pins
    output logic             wait_in,
    output logic             bus_request_in,
    output logic             ext_int0_in,
    output logic             ext_int1_in,
    output logic             conversion_trigger_in,
    // control bits for observation
    output logic             bus_release_enable
);
    pfs_bus_state_t state_r;
    logic [7:0] p1_ddr_r;
    logic [7:0] p1_data_r;
    logic [4:0] ctrl_r;
    logic [7:0] p1_out_nxt;
    logic [7:0] p1_oe_nxt;
    logic [4:0] p2_out_nxt;
    logic [4:0] p2_oe_nxt;
    logic [7:0] p2_data_rd;

    wire req       = (avs_read || avs_write) && state_r == PFS_IDLE;
    wire hit_p1ddr = avs_address == `PFS_P1_DDR_ADDR;
    wire hit_port2_direction = avs_address == `PFS_P2_DDR_ADDR;
    wire hit_p1dat = avs_address == `PFS_P1_DATA_ADDR;
    wire hit_p2dat = avs_address == `PFS_P2_DATA_ADDR;
    wire hit_ctrl  = avs_address == `PFS_CTRL_ADDR;
    wire wr        = req && avs_write;

    wire wait_select_hi_bit = ctrl_r[`PFS_CTL_WAIT_SEL];
    wire bus_rel_on         = ctrl_r[`PFS_CTL_BUS_REL] && expanded;
    wire int0e              = ctrl_r[`PFS_CTL_INT0E];
    wire int1e              = ctrl_r[`PFS_CTL_INT1E];
    wire ext_trigger_enable = ctrl_r[`PFS_CTL_TRIG_EN];
    wire timer_out_on       = |timer_output_select;
    wire wait_sel           = wait_select_hi_bit && expanded;

    // per-pin oe: peripheral input functions disable the driver
    assign p1_oe_nxt[0] = p1_ddr_r[0];
    assign p1_oe_nxt[1] = p1_ddr_r[1];
    assign p1_oe_nxt[2] = bus_rel_on | p1_ddr_r[2];
    assign p1_oe_nxt[3] = !bus_rel_on && p1_ddr_r[3];
    assign p1_oe_nxt[4] = !wait_sel && p1_ddr_r[4];
    assign p1_oe_nxt[5] = !int0e && p1_ddr_r[5];
    assign p1_oe_nxt[6] = !int1e && !ext_trigger_enable && p1_ddr_r[6];
    assign p1_oe_nxt[7] = timer_out_on | p1_ddr_r[7];
    assign p1_out_nxt = {timer_out_on ? timer_compare_out : p1_data_r[7],
                         p1_data_r[6:3],
                         bus_rel_on ? bus_ack_out : p1_data_r[2],
                         e_clock, sys_clock};

    // read value: driven output value (latch, or clock, bus acknowledge or timer output) for driven pins, live pin otherwise
    wire [7:0] p1_rd = (p1_oe_nxt & p1_out_nxt) | (~p1_oe_nxt & p1_in);
    wire [7:0] ctrl_rd = {3'b000, ctrl_r};
    wire [7:0] rd_mux = (hit_p1ddr || hit_port2_direction) ? 8'hff :
                        hit_p1dat ? p1_rd :
                        hit_p2dat ? p2_data_rd :
                        hit_ctrl  ? ctrl_rd : `PFS_UNMAPPED;

    pfs_port2 u_port2 (
        .clk         (clk),
        .resetn      (resetn),
        .expanded    (expanded),
        .hw_standby  (hw_standby),
        .ddr_wr      (wr && hit_port2_direction),
        .data_wr     (wr && hit_p2dat),
        .wdata       (avs_writedata),
        .bus_ctl     (bus_ctl),
        .pin_in      (p2_in),
        .pin_out_nxt (p2_out_nxt),
        .pin_oe_nxt  (p2_oe_nxt),
        .data_rd     (p2_data_rd)
    );

    // one wait cycle per access; answer in the second cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r         <= PFS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 8'h00;
        end else begin
            case (state_r)
                PFS_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_r         <= PFS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? rd_mux : 8'h00;
                    end
                end
                default: begin
                    state_r         <= PFS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_ddr_r  <= `PFS_P1_DDR_RST;
            p1_data_r <= `PFS_P1_DATA_RST;
            ctrl_r    <= 5'h00;
        end else if (hw_standby) begin
            p1_ddr_r  <= `PFS_P1_HSB;
            p1_data_r <= `PFS_P1_DATA_RST;
            ctrl_r    <= 5'h00;
        end else begin
            if (wr && hit_p1ddr)
                p1_ddr_r <= avs_writedata;
            if (wr && hit_p1dat)
                p1_data_r <= avs_writedata;
            if (wr && hit_ctrl)
                ctrl_r <= avs_writedata[4:0];
        end
    end

    // registered pin drivers and peripheral inputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_out                <= 8'h00;
            p1_oe                 <= `PFS_P1_DDR_RST;           // clock pins drive from reset
            p2_out                <= 5'h00;
            p2_oe                 <= 5'h00;
            wait_in               <= 1'b1;
            bus_request_in        <= 1'b1;
            ext_int0_in           <= 1'b1;
            ext_int1_in           <= 1'b1;
            conversion_trigger_in <= 1'b1;
            bus_release_enable    <= 1'b0;
        end else begin
            p1_out                <= p1_out_nxt;
            p1_oe                 <= p1_oe_nxt;
            p2_out                <= p2_out_nxt;
            p2_oe                 <= p2_oe_nxt;
            wait_in               <= wait_sel ? p1_in[4] : 1'b1;
            bus_request_in        <= bus_rel_on ? p1_in[3] : 1'b1;
            ext_int0_in           <= int0e ? p1_in[5] : 1'b1;
            ext_int1_in           <= int1e ? p1_in[6] : 1'b1;
            conversion_trigger_in <= ext_trigger_enable ? p1_in[6] : 1'b1;
            bus_release_enable    <= bus_rel_on;
        end
    end

    // two-step behaviours: a direction write or a standby, then a cycle still in single-chip mode; then a one-cycle port2 data read
    sequence p2_dir_write_s;
        (wr && hit_port2_direction && !expanded && !hw_standby) ##1 !expanded;
    endsequence
    sequence p2_standby_s;
        hw_standby ##1 !expanded;
    endsequence
    sequence p2_data_read_s;
        state_r == PFS_IDLE && avs_read && hit_p2dat;
    endsequence

    AST_P2_EXP_OE: assert property (@(posedge clk) disable iff (!resetn)
        expanded |=> p2_oe == 5'h1f) else $error("port2 not driven in expanded mode");
    AST_DDR_READ: assert property (@(posedge clk) disable iff (!resetn)
        (state_r == PFS_IDLE && avs_read && (hit_p1ddr || hit_port2_direction)) |=> avs_readdata == 8'hff)
        else $error("direction read not all ones");
    AST_P17_TMO: assert property (@(posedge clk) disable iff (!resetn)
        timer_out_on |=> p1_oe[7]) else $error("timer output not driven");
    AST_P15_INT: assert property (@(posedge clk) disable iff (!resetn)
        int0e |=> !p1_oe[5]) else $error("interrupt pin driven");
    AST_P16_IN: assert property (@(posedge clk) disable iff (!resetn)
        (int1e || ext_trigger_enable) |=> !p1_oe[6]) else $error("pin6 driven as input");
    AST_P13_SC: assert property (@(posedge clk) disable iff (!resetn)
        !expanded |=> p1_oe[3] == $past(p1_ddr_r[3])) else $error("pin3 not plain io");
    AST_P2_SC: assert property (@(posedge clk) disable iff (!resetn)
        p2_dir_write_s |=> p2_oe == $past(avs_writedata[4:0], 2)) else $error("port2 oe not from direction write");
    AST_P2_STROBE: assert property (@(posedge clk) disable iff (!resetn)
        expanded |=> p2_out == $past(bus_ctl)) else $error("strobes not routed");
    AST_WAIT_SEL: assert property (@(posedge clk) disable iff (!resetn)
        (expanded && wait_select_hi_bit) |=> !p1_oe[4]) else $error("wait pin driven");
    AST_P12_ACK: assert property (@(posedge clk) disable iff (!resetn)
        bus_rel_on |=> p1_oe[2] && p1_out[2] == $past(bus_ack_out)) else $error("bus acknowledge not driven");
    AST_P16_IO: assert property (@(posedge clk) disable iff (!resetn)
        (!int1e && !ext_trigger_enable) |=> p1_oe[6] == $past(p1_ddr_r[6])) else $error("pin6 direction wrong");
    AST_P14_SC: assert property (@(posedge clk) disable iff (!resetn)
        !expanded |=> p1_oe[4] == $past(p1_ddr_r[4]) && p1_oe[2] == $past(p1_ddr_r[2]))
        else $error("pins 4 and 2 not plain io");
    AST_P11_CLK: assert property (@(posedge clk) disable iff (!resetn)
        p1_ddr_r[1] |=> p1_oe[1] && p1_out[1] == $past(e_clock)) else $error("e clock not driven");
    AST_P2_HSB: assert property (@(posedge clk) disable iff (!resetn)
        p2_standby_s |=> p2_oe == 5'h00) else $error("standby left port2 driving");
    AST_P2_RSVD: assert property (@(posedge clk) disable iff (!resetn)
        p2_data_read_s |=> avs_readdata[7:5] == 3'b111) else $error("reserved bits not one");
endmodule : pfs_top

// ### test/pfs_pin_model.sv
// board-level pads: a driven pad shows the chip, else the outside level
`timescale 1ns/10ps
module pfs_pin_model (
    // chip drive
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe,
    input  wire logic [4:0] p2_out,
    input  wire logic [4:0] p2_oe,
    // outside drivers
    input  wire logic [7:0] p1_ext,
    input  wire logic [4:0] p2_ext,
    // resolved pad levels
    output logic      [7:0] p1_in,
    output logic      [4:0] p2_in
);
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_ext);
    assign p2_in = (p2_oe & p2_out) | (~p2_oe & p2_ext);
endmodule : pfs_pin_model

// ### test/port1_port2_pin_function_select_bench.sv
// self-checking bench for the port 1 / port 2 function select block
`timescale 1ns/10ps
`include "pfs_map.svh"
module port1_port2_pin_function_select_bench import pfs_pkg::*;;
    logic        clk = 0, resetn = 0, avs_read = 0, avs_write = 0;
    logic [15:0] avs_address = 16'h0000;
    logic [7:0]  avs_writedata = 8'h00, avs_readdata, rd, p1_in, p1_out, p1_oe, p1_ext = 8'h00;
    logic        avs_waitrequest, expanded = 0, hw_standby = 0, timer_compare_out = 0;
    logic        e_clock = 1, sys_clock = 0, bus_ack_out = 1, bus_release_enable;
    logic [3:0]  timer_output_select = 4'h0;
    logic [4:0]  bus_ctl = 5'h00, p2_in, p2_out, p2_oe, p2_ext = 5'h0a;
    logic        wait_in, bus_request_in, ext_int0_in, ext_int1_in, conversion_trigger_in;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;
    pfs_top pfs_top_inst (.*);
    pfs_pin_model pfs_pin_model_inst (.*);
    initial forever #4 clk = ~clk;
    // hang guard, far above the eighty or so cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    task close_out();
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // held until waitrequest is seen low at an edge
    task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk);
    endtask : bus
    // outputs are read in the active region, so they show what the previous edge launched
    task settle();
        repeat (2) @(posedge clk);
    endtask : settle
    task t_reset();
        chk(p1_oe, 8'h03);
        chk(p1_out[1:0], 8'h02);
        chk(p2_oe, 8'h00);
        bus(0, `PFS_P2_DDR_ADDR, 8'h00);
        chk(rd, 8'hff);
        bus(0, `PFS_P2_DATA_ADDR, 8'h00);
        chk(rd, 8'hea);
    endtask : t_reset
    task t_p2();
        bus(1, `PFS_P2_DDR_ADDR, 8'h15);
        bus(1, `PFS_P2_DATA_ADDR, 8'h10);
        settle();
        chk(p2_oe, 8'h15);
        chk(p2_out & 5'h15, 8'h10);
        bus(0, `PFS_P2_DATA_ADDR, 8'h00);
        chk(rd, 8'hfa);
        bus(0, `PFS_P2_DDR_ADDR, 8'h00);
        chk(rd, 8'hff);
        bus(1, `PFS_P2_DATA_ADDR, 8'h00);
        bus(0, `PFS_P2_DATA_ADDR, 8'h00);
        chk(rd, 8'hea);
        hw_standby <= 1;
        @(posedge clk);
        hw_standby <= 0;
        settle();
        chk(p2_oe, 8'h00);
    endtask : t_p2
    task t_exp();
        bus(1, `PFS_CTRL_ADDR, 8'h03);
        bus(1, `PFS_P1_DDR_ADDR, 8'h18);
        expanded <= 1;
        bus_ctl <= 5'h15;
        settle();
        chk(p2_oe, 8'h1f);
        chk(p2_out, 8'h15);
        bus(1, `PFS_P2_DDR_ADDR, 8'h1f);
        bus_ctl <= 5'h0a;
        settle();
        chk(p2_oe, 8'h1f);
        chk(p2_out, 8'h0a);
        chk(p1_oe[4:2], 8'h01);
        chk(p1_out[2], 8'h01);
        chk(bus_request_in, 8'h00);
        chk(bus_release_enable, 8'h01);
        chk(wait_in, 8'h00);
        expanded <= 0;
        settle();
        chk(p2_oe, 8'h00);
        chk(bus_release_enable, 8'h00);
        chk(p1_oe[4:2], 8'h06);
        chk(bus_request_in, 8'h01);
        chk(wait_in, 8'h01);
    endtask : t_exp
    task t_p1();
        bus(1, `PFS_CTRL_ADDR, 8'h1c);
        bus(1, `PFS_P1_DDR_ADDR, 8'h60);
        settle();
        chk(p1_oe[6:5], 8'h00);
        chk({ext_int0_in, ext_int1_in, conversion_trigger_in}, 8'h00);
        p1_ext <= 8'h60;
        bus(0, `PFS_P1_DATA_ADDR, 8'h00);
        chk(rd & 8'h60, 8'h60);
        p1_ext <= 8'h00;
        bus(1, `PFS_CTRL_ADDR, 8'h10);
        settle();
        chk({ext_int1_in, conversion_trigger_in, p1_oe[6]}, 8'h04);
        bus(1, `PFS_CTRL_ADDR, 8'h00);
        settle();
        chk(p1_oe[6:5], 8'h03);
        for (int i = 0; i < 4; i++) begin
            timer_output_select <= 4'h1 << i;
            timer_compare_out <= i[0];
            settle();
            chk({p1_oe[7], p1_out[7]}, {6'h00, 1'b1, i[0]});
        end
        timer_output_select <= 4'h0;
        settle();
        chk(p1_oe[7], 8'h00);
    endtask : t_p1
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1;
        settle();
        t_reset();
        t_p2();
        t_exp();
        t_p1();
        close_out();
    end
endmodule : port1_port2_pin_function_select_bench
